// ===== logic/eeprom_cfg.svh
// Constants for the two-wire serial data memory slave
//
// Functional notes
// - Data may change only while clock low; high-clock changes are start or stop.
// - Data falling while clock high is a start; every command begins with one.
// - Data rising while clock high is a stop; every operation ends with one.
// - One bit per clock pulse, valid while clock high; master sets byte count.
// - Receiver acknowledges every byte on a ninth clock pulse from the master.
// - Acknowledger holds data low through the whole high phase of that pulse.
// - After master withholds acknowledge on a read byte, slave releases data high.
// - No acknowledge of any byte while an internal write cycle runs.
// - First byte after start: four-bit type code, three ignored bits, direction bit.
// - Direction bit one selects read, zero selects write.
// - Slave always watches; acknowledges control byte only on code match and not busy.
// - Byte after write control byte loads pointer; only low four bits used.
// - Stop after acknowledged address and data starts timed write; no acknowledge meanwhile.
// - After byte write the address pointer stays on the written location.
// - Stop before write sequence completes aborts, memory unchanged.
// - More than eight data bits discard the loaded byte and refill the buffer.
// - Several data bytes and stop before a full byte aborts; nothing stored.
// - Data line open-drain with pull-up; host writes one before reading; both reset high.
// - Data and clock lines are bits six and seven of port register six.
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH

`define PORT_IDX 8'h06
`define STAT_IDX 8'h07
`define SCL_BIT 7
`define SDA_BIT 6
`define GP_W 6
`define STAT_BUSY 0
`define STAT_ACTIVE 1
`define STAT_PTR 4
`define MEM_DEPTH 16
`define BYTE_BITS 4'h8
`define BUSY_W 17
`define CLK_PERIOD_NS 40
`define WRITE_TIME_NS 4000000

`endif

// ===== logic/eeprom_pkg.sv
// Types shared by the serial data memory slave
`default_nettype none
package eeprom_pkg;
    `include "eeprom_cfg.svh"

    typedef enum logic [2:0] {ph_idle, ph_ctrl, ph_addr, ph_data, ph_read, ph_ignore} phase_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic scl_q;
        logic sda_q;
        logic [`GP_W-1:0] gp;
        logic [31:0] prdata;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] prev;
        phase_t phase;
        logic [3:0] bitcnt;
        logic in_ack;
        logic pull;
        logic macked;
        logic [7:0] shreg;
        logic [7:0] tx;
        logic dvalid;
        logic [7:0] dbuf;
        logic [3:0] ptr;
        logic busy;
        logic [`BUSY_W-1:0] timer;
        logic [`MEM_DEPTH-1:0][7:0] mem;
    } ee_state_t;
endpackage
`default_nettype wire

// ===== logic/serial_eeprom_slave.sv
// Two-wire serial data memory slave behind an APB port register
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_cfg.svh"
module serial_eeprom_slave #(
    parameter logic [3:0] dev_code = 4'h5, // Type code value is arbitrary
    parameter int unsigned write_cycles = `WRITE_TIME_NS / `CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire eeprom_pkg::apb_req_t apb_req,
    output var eeprom_pkg::apb_rsp_t apb_rsp,
    output logic scl_line,
    output logic sda_release,
    output logic mem_pull,
    output logic busy
);
    import eeprom_pkg::*;

    localparam logic [7:0] PORT_ADDR = `PORT_IDX << 2;
    localparam logic [7:0] STAT_ADDR = `STAT_IDX << 2;
    localparam logic [`BUSY_W-1:0] WRITE_LOAD = `BUSY_W'(write_cycles);
    localparam ee_state_t RESET_ST = '{
        scl_q: 1'b1, sda_q: 1'b1, gp: '0, prdata: '0,
        sync1: 2'b11, sync2: 2'b11, prev: 2'b11,
        phase: ph_idle, bitcnt: '0, in_ack: 1'b0, pull: 1'b0, macked: 1'b0,
        shreg: '0, tx: '0, dvalid: 1'b0, dbuf: '0, ptr: '0,
        busy: 1'b0, timer: '0, mem: '0
    };

    ee_state_t st;
    ee_state_t next_st;
    logic [1:0] line;
    logic scl_hi;
    logic start_evt;
    logic stop_evt;
    logic rise;
    logic fall;
    logic byte_done;
    logic write_ok;
    logic setup_acc;
    logic wr_acc;
    logic hit;

    // Software drives both lines; the memory can only pull data low
    assign line = {st.scl_q, st.sda_q & ~st.pull};

    assign scl_hi = st.sync2[1] & st.prev[1];
    assign start_evt = scl_hi & st.prev[0] & ~st.sync2[0];
    assign stop_evt = scl_hi & ~st.prev[0] & st.sync2[0];
    assign rise = st.sync2[1] & ~st.prev[1];
    assign fall = ~st.sync2[1] & st.prev[1];
    assign byte_done = fall & ~st.in_ack & (st.bitcnt == `BYTE_BITS);
    // write only with a whole acked data byte and no newer full bit
    assign write_ok = (st.phase == ph_data) & st.dvalid & ~st.in_ack & (st.bitcnt <= 4'h1);

    assign setup_acc = apb_req.psel & ~apb_req.penable;
    assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite & ce;
    assign hit = (apb_req.paddr == PORT_ADDR) | (apb_req.paddr == STAT_ADDR);

    // Zero wait states: ready simply follows the clock enable
    assign apb_rsp = '{prdata: st.prdata, pready: ce,
                       pslverr: apb_req.psel & apb_req.penable & ~hit};
    assign scl_line = st.scl_q;
    assign sda_release = st.sda_q;
    assign mem_pull = st.pull;
    assign busy = st.busy;

    always_comb begin
        next_st = st;
        if (ce) begin
            // Line samplers; first stage is read only by the second
            next_st.sync1 = line;
            next_st.sync2 = st.sync1;
            next_st.prev = st.sync2;

            // Read data captured in the setup cycle so it comes from a flip-flop
            if (setup_acc) begin
                next_st.prdata = '0;
                if (apb_req.paddr == PORT_ADDR) begin
                    // lines in bits seven and six, read as the wire levels
                    next_st.prdata[`SCL_BIT] = line[1];
                    next_st.prdata[`SDA_BIT] = line[0];
                    next_st.prdata[`GP_W-1:0] = st.gp;
                end else if (apb_req.paddr == STAT_ADDR) begin
                    next_st.prdata[`STAT_BUSY] = st.busy;
                    next_st.prdata[`STAT_ACTIVE] = (st.phase != ph_idle);
                    next_st.prdata[`STAT_PTR +: 4] = st.ptr;
                end
            end
            if (wr_acc && apb_req.paddr == PORT_ADDR) begin
                // writing one releases data to the pull-up
                next_st.scl_q = apb_req.pwdata[`SCL_BIT];
                next_st.sda_q = apb_req.pwdata[`SDA_BIT];
                next_st.gp = apb_req.pwdata[`GP_W-1:0];
            end

            if (st.busy) begin
                next_st.timer = st.timer - `BUSY_W'(1);
                if (st.timer == `BUSY_W'(1)) begin
                    next_st.busy = 1'b0;
                end
            end

            if (start_evt) begin
                // a start always begins a new control byte
                next_st.phase = ph_ctrl;
                next_st.bitcnt = '0;
                next_st.in_ack = 1'b0;
                next_st.pull = 1'b0;
                next_st.dvalid = 1'b0;
            end else if (stop_evt) begin
                // stop after a complete write launches programming
                if (write_ok) begin
                    next_st.mem[st.ptr] = st.dbuf;
                    next_st.busy = 1'b1;
                    next_st.timer = WRITE_LOAD;
                end
                next_st.phase = ph_idle;
                next_st.bitcnt = '0;
                next_st.in_ack = 1'b0;
                next_st.pull = 1'b0;
                next_st.dvalid = 1'b0;
            end else if (st.phase != ph_idle && st.phase != ph_ignore) begin
                if (rise) begin
                    if (st.in_ack) begin
                        next_st.macked = ~st.sync2[0];
                    end else if (st.bitcnt < `BYTE_BITS) begin
                        // one bit taken per clock rise
                        next_st.shreg = {st.shreg[6:0], st.sync2[0]};
                        next_st.bitcnt = st.bitcnt + 4'h1;
                    end
                end else if (fall) begin
                    if (st.in_ack) begin
                        // acknowledge held until the ninth clock falls
                        next_st.in_ack = 1'b0;
                        next_st.bitcnt = '0;
                        next_st.pull = 1'b0;
                        if (st.phase == ph_read) begin
                            if (st.macked) begin
                                next_st.tx = st.mem[st.ptr];
                                next_st.pull = ~st.mem[st.ptr][7];
                            end else begin
                                // no master acknowledge: release and stand aside
                                next_st.phase = ph_ignore;
                            end
                        end
                    end else if (st.bitcnt == `BYTE_BITS) begin
                        next_st.in_ack = 1'b1;
                        next_st.pull = 1'b0;
                        unique case (st.phase)
                            ph_ctrl: begin
                                // acknowledge only a matching code when idle
                                if (st.shreg[7:4] == dev_code && !st.busy) begin
                                    // direction bit picks read or write
                                    next_st.phase = st.shreg[0] ? ph_read : ph_addr;
                                    next_st.macked = 1'b1;
                                    next_st.pull = 1'b1;
                                end else begin
                                    next_st.phase = ph_ignore;
                                    next_st.in_ack = 1'b0;
                                end
                            end
                            ph_addr: begin
                                next_st.ptr = st.shreg[3:0];
                                next_st.phase = ph_data;
                                next_st.pull = ~st.busy;
                            end
                            ph_data: begin
                                next_st.dbuf = st.shreg;
                                next_st.dvalid = 1'b1;
                                next_st.pull = ~st.busy;
                            end
                            ph_read: begin
                                // Pointer advances once a byte has been sent
                                next_st.ptr = st.ptr + 4'h1;
                            end
                            default: begin
                                next_st.in_ack = 1'b0;
                            end
                        endcase
                    end else if (st.phase == ph_read) begin
                        next_st.pull = ~st.tx[3'(4'h7 - st.bitcnt)];
                    end else if (st.phase == ph_data && st.bitcnt == 4'h1) begin
                        // a ninth data bit drops the loaded byte
                        next_st.dvalid = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= RESET_ST;
        end else begin
            st <= next_st;
        end
    end

    // Properties sample only on enabled cycles, when state can move
    default clocking cb @(posedge clk iff ce);
    endclocking
    default disable iff (!rst_n);

    a_start_ctrl:
    assert property (start_evt |=> st.phase == ph_ctrl && st.bitcnt == 4'h0 && !st.pull)
        else $error("start did not open a control byte");

    a_stop_idle:
    assert property (stop_evt |=> st.phase == ph_idle && !st.pull && !st.in_ack)
        else $error("stop did not return to idle");

    a_bit_count:
    assert property (rise && !start_evt && !stop_evt && !st.in_ack && st.bitcnt < `BYTE_BITS
        && st.phase inside {ph_ctrl, ph_addr, ph_data}
        |=> st.bitcnt == $past(st.bitcnt) + 4'h1 && st.shreg[0] == $past(st.sync2[0]))
        else $error("received bit not counted");

    a_ack_busy:
    assert property (st.busy && st.phase != ph_read |-> !st.pull)
        else $error("acknowledge driven during write cycle");

    a_ctrl_match:
    assert property (byte_done && !start_evt && !stop_evt && st.phase == ph_ctrl
        |=> st.pull == ($past(st.shreg[7:4]) == dev_code && !$past(st.busy)))
        else $error("control byte acknowledge mismatch");

    a_addr_load:
    assert property (byte_done && !start_evt && !stop_evt && st.phase == ph_addr
        |=> st.ptr == $past(st.shreg[3:0]) && st.phase == ph_data)
        else $error("word address not loaded");

    a_ack_hold:
    assert property (st.in_ack && st.pull && !fall && !start_evt && !stop_evt |=> st.pull)
        else $error("acknowledge released before clock fell");

    a_write_len:
    assert property ($rose(st.busy) |-> st.busy [*8] ##0 st.timer == WRITE_LOAD - `BUSY_W'(7))
        else $error("write cycle ended early");

    a_ptr_hold:
    assert property ($rose(st.busy) |-> st.ptr == $past(st.ptr)
        && st.mem[st.ptr] == $past(st.dbuf))
        else $error("pointer moved or data not stored on write");

    a_abort_stop:
    assert property (stop_evt && !write_ok && !st.busy |=> !st.busy && st.mem == $past(st.mem))
        else $error("aborted write changed memory");

    a_nack_release:
    assert property (fall && st.in_ack && st.phase == ph_read && !st.macked
        && !start_evt && !stop_evt |=> !st.pull ##1 !st.pull)
        else $error("data line not released after master nack");

    a_dir_select:
    assert property (byte_done && st.phase == ph_ctrl && st.shreg[7:4] == dev_code && !st.busy
        |=> st.phase == ($past(st.shreg[0]) ? ph_read : ph_addr))
        else $error("direction bit not decoded");

    a_addr_ack:
    assert property (byte_done && st.phase == ph_addr && !st.busy |=> st.pull && st.in_ack)
        else $error("address byte not acknowledged");

    a_data_load:
    assert property (byte_done && st.phase == ph_data
        |=> st.dbuf == $past(st.shreg) && st.dvalid && st.in_ack)
        else $error("data byte not loaded");

    a_overrun_drop:
    assert property (fall && !st.in_ack && st.phase == ph_data && st.bitcnt == 4'h1
        |=> !st.dvalid)
        else $error("overrun byte not dropped");

    a_partial_abort:
    assert property (stop_evt && st.phase == ph_data && !st.dvalid
        |=> !st.busy && st.mem == $past(st.mem))
        else $error("cut data byte was stored");

    a_busy_end:
    assert property (st.busy && st.timer == `BUSY_W'(1) |=> !st.busy)
        else $error("write cycle overran");

    a_timer_step:
    assert property (st.busy && st.timer != `BUSY_W'(1)
        |=> st.busy && st.timer == $past(st.timer) - `BUSY_W'(1))
        else $error("write timer did not count down");

    // Timer and flag must agree, or a stuck flag would lock the memory out
    a_busy_timer:
    assert property (st.busy |-> st.timer != '0)
        else $error("busy with an empty timer");

    a_pull_only_ack:
    assert property (!st.in_ack && st.phase != ph_read |-> !st.pull)
        else $error("data pulled outside acknowledge");

    a_ignore_quiet:
    assert property (st.phase == ph_ignore |-> !st.pull && !st.in_ack)
        else $error("ignored transfer drives the line");

    a_idle_quiet:
    assert property (st.phase == ph_idle |-> !st.pull && !st.in_ack)
        else $error("idle bus drives the line");

    a_port_write:
    assert property (wr_acc && apb_req.paddr == PORT_ADDR
        |=> st.scl_q == $past(apb_req.pwdata[`SCL_BIT])
        && st.sda_q == $past(apb_req.pwdata[`SDA_BIT]))
        else $error("port write did not reach the lines");

    // Port reads show the wire, so a pulled-low data line reads as zero
    a_port_read:
    assert property (setup_acc && apb_req.paddr == PORT_ADDR
        |=> st.prdata[`SCL_BIT] == $past(line[1]) && st.prdata[`SDA_BIT] == $past(line[0]))
        else $error("port read does not show the lines");

    a_stat_read:
    assert property (setup_acc && apb_req.paddr == STAT_ADDR
        |=> st.prdata[`STAT_PTR +: 4] == $past(st.ptr)
        && st.prdata[`STAT_BUSY] == $past(st.busy))
        else $error("status read does not show pointer or busy");

    a_read_bit:
    assert property (fall && !st.in_ack && st.phase == ph_read && st.bitcnt != `BYTE_BITS
        |=> st.pull == !$past(st.tx[3'(4'h7 - st.bitcnt)]))
        else $error("read bit not put on the line");

    a_ptr_read_step:
    assert property (byte_done && st.phase == ph_read
        |=> st.ptr == $past(st.ptr) + 4'h1 && !st.pull && st.in_ack)
        else $error("pointer not advanced after a sent byte");
endmodule
`default_nettype wire

// ===== verification/host_master.sv
// Host-side model: APB master moving the serial lines through the port register
`timescale 1ns/1ps
`default_nettype none
module host_master (
    input wire logic clk,
    output var eeprom_pkg::apb_req_t apb_req,
    input wire eeprom_pkg::apb_rsp_t apb_rsp
);
    import eeprom_pkg::*;
    logic [7:0] lines = 8'hC0;
    initial apb_req = '0;

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, wr, addr, wd};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do @(posedge clk); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask

    // both lines set per write, data released by a one
    task automatic drive(input logic s, input logic d);
        logic [31:0] rd;
        logic err;
        lines[7:6] = {s, d};
        apb(1'b1, 8'h18, {24'h0, lines}, rd, err);
        // Spacing lets the slave's synchroniser see every change
        repeat (2) @(posedge clk);
    endtask

    task automatic sample(output logic v);
        logic [31:0] rd;
        logic err;
        apb(1'b0, 8'h18, '0, rd, err);
        v = rd[6];
    endtask

    task automatic start();
        drive(1'b1, 1'b1);
        drive(1'b1, 1'b0);
        drive(1'b0, 1'b0);
    endtask

    task automatic stop();
        drive(1'b0, 1'b0);
        drive(1'b1, 1'b0);
        drive(1'b1, 1'b1);
    endtask

    task automatic send_byte(input logic [7:0] b, input int n, output logic ack);
        logic v;
        ack = 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            drive(1'b0, b[i]);
            drive(1'b1, b[i]);
            drive(1'b0, b[i]);
        end
        if (n == 8) begin
            drive(1'b0, 1'b1);
            drive(1'b1, 1'b1);
            sample(v);
            ack = ~v;
            drive(1'b0, 1'b1);
        end
    endtask

    task automatic read_byte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            drive(1'b0, 1'b1);
            drive(1'b1, 1'b1);
            sample(b[i]);
        end
        drive(1'b0, 1'b1);
        drive(1'b1, 1'b1);
        drive(1'b0, 1'b1);
    endtask
endmodule
`default_nettype wire

// ===== verification/test_internal_serial_eeprom_slave.sv
// Self-checking bench for the serial data memory slave
`timescale 1ns/1ps
`default_nettype none
module test_internal_serial_eeprom_slave;
    import eeprom_pkg::*;
    localparam logic [3:0] code = 4'h9; // Type code value is arbitrary
    localparam int wcyc = 400;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    apb_req_t apb_req;
    apb_rsp_t apb_rsp;
    logic scl_line, sda_release, mem_pull, busy;
    int err_total = 0;
    int cmp_count = 0;
    logic [7:0] shadow [16];

    always #20 clk = ~clk;

    serial_eeprom_slave #(.dev_code(code), .write_cycles(wcyc)) uut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .scl_line(scl_line), .sda_release(sda_release), .mem_pull(mem_pull), .busy(busy));
    host_master host (.clk(clk), .apb_req(apb_req), .apb_rsp(apb_rsp));

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: %s got %b", $time, msg, got);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic [7:0] exp_status(input logic [3:0] p, input logic act,
                                              input logic bsy);
        return {p, 2'h0, act, bsy};
    endfunction

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        conclude();
    end

    initial begin
        logic [31:0] rd;
        logic err, ack;
        logic [7:0] a, d0, d1, got;
        logic [5:0] g;
        void'($urandom(32'h3d99_11cf));
        foreach (shadow[i]) shadow[i] = 8'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        host.apb(1'b0, 8'h18, '0, rd, err);
        chk_byte({rd[7:6], 6'h00}, 8'hC0, "port reset");
        host.apb(1'b0, 8'h1C, '0, rd, err);
        chk_byte(rd[7:0], exp_status(4'h0, 1'b0, 1'b0), "status reset");
        chk_bit(scl_line, 1'b1, "clock line reset");
        chk_bit(sda_release, 1'b1, "data latch reset");
        chk_bit(mem_pull, 1'b0, "pull reset");
        g = 6'($urandom);
        host.apb(1'b1, 8'h18, {24'h0, 2'h3, g}, rd, err);
        host.apb(1'b0, 8'h18, '0, rd, err);
        chk_byte(rd[7:0], {2'h3, g}, "port latch");
        host.apb(1'b0, 8'h20, '0, rd, err);
        chk_bit(err, 1'b1, "unmapped error");
        chk_byte(rd[7:0], 8'h00, "unmapped data");
        host.start();
        host.send_byte({~code, 4'h0}, 8, ack);
        chk_bit(ack, 1'b0, "foreign code");
        host.stop();
        // 0 plain, 1 overrun, 2 stop after address, 3 partial byte
        for (int t = 0; t < 4; t++) begin
            a = 8'($urandom);
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            host.start();
            host.send_byte({code, 3'($urandom), 1'b0}, 8, ack);
            chk_bit(ack, 1'b1, "control ack");
            host.send_byte(a, 8, ack);
            chk_bit(ack, 1'b1, "address ack");
            if (t != 2) begin
                host.send_byte(d0, 8, ack);
                chk_bit(ack, 1'b1, "data ack");
            end
            if (t % 2 == 1) begin
                host.send_byte(d1, 8, ack);
                chk_bit(ack, 1'b1, "extra data ack");
            end
            if (t == 3) host.send_byte(d0, 3, ack);
            host.stop();
            if (t < 2) shadow[a[3:0]] = (t == 1) ? d1 : d0;
            repeat (6) @(posedge clk);
            chk_bit(busy, logic'(t < 2), "busy after stop");
            chk_bit(mem_pull, 1'b0, "released after stop");
            chk_bit(scl_line & sda_release, 1'b1, "idle lines");
            if (t == 0) begin
                host.start();
                host.send_byte({code, 4'h0}, 8, ack);
                chk_bit(ack, 1'b0, "ack while busy");
                host.apb(1'b0, 8'h1C, '0, rd, err);
                chk_byte(rd[7:0], exp_status(a[3:0], 1'b1, 1'b1), "status busy");
                host.stop();
                // Acknowledge polling: resend the control byte until the cycle ends
                for (int p = 0; p < 8 && ack !== 1'b1; p++) begin
                    host.start();
                    host.send_byte({code, 4'h0}, 8, ack);
                    host.stop();
                end
                chk_bit(ack, 1'b1, "poll ack");
            end else if (t == 1) begin
                ce <= 1'b0;
                repeat (wcyc + 20) @(posedge clk);
                chk_bit(busy, 1'b1, "busy frozen");
                ce <= 1'b1;
            end
            for (int n = 0; n < wcyc + 10 && busy === 1'b1; n++) @(posedge clk);
            chk_bit(busy, 1'b0, "busy end");
            host.apb(1'b0, 8'h1C, '0, rd, err);
            chk_byte(rd[7:0], exp_status(a[3:0], 1'b0, 1'b0), "pointer");
            host.start();
            host.send_byte({code, 4'h1}, 8, ack);
            chk_bit(ack, 1'b1, "read control ack");
            host.read_byte(got);
            chk_byte(got, shadow[a[3:0]], "read back");
            host.stop();
            $display("test %0d done", t);
        end
        conclude();
    end
endmodule
`default_nettype wire
